/* design/tcc_pkg.sv */
package tcc_pkg;
  // register byte offsets, one aligned word per 8-bit location
  localparam logic [7:0] OFS_CTRL_A      = 8'h00;
  localparam logic [7:0] OFS_CTRL_B      = 8'h04;
  localparam logic [7:0] OFS_COUNT_LO    = 8'h08;
  localparam logic [7:0] OFS_COUNT_HI    = 8'h0c;
  localparam logic [7:0] OFS_CAPTURE_LO  = 8'h10;
  localparam logic [7:0] OFS_CAPTURE_HI  = 8'h14;
  localparam logic [7:0] OFS_COMPARE_ALO = 8'h18;
  localparam logic [7:0] OFS_COMPARE_AHI = 8'h1c;
  localparam logic [7:0] OFS_COMPARE_BLO = 8'h20;
  localparam logic [7:0] OFS_COMPARE_BHI = 8'h24;
  localparam logic [7:0] OFS_IRQ_MASK    = 8'h28;
  localparam logic [7:0] OFS_IRQ_FLAGS   = 8'h2c;
  localparam logic [7:0] OFS_CMP_CTRL    = 8'h30;

  // field positions
  localparam int CTRL_B_FILTER_BIT = 7;
  localparam int CTRL_B_EDGE_BIT   = 6;
  localparam int CTRL_B_MODE_LSB   = 3;
  localparam int CTRL_B_CLKSEL_LSB = 0;
  localparam int CTRL_A_MODE_LSB   = 0;
  localparam int IRQ_OVERFLOW_BIT  = 0;
  localparam int IRQ_CAPTURE_BIT   = 5;
  localparam int CMP_CAPSEL_BIT    = 2;

  // reset values
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // counter limits
  localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
  localparam logic [15:0] COUNT_MAX    = 16'hffff;
  localparam logic [15:0] TOP_8BIT     = 16'h00ff;
  localparam logic [15:0] TOP_9BIT     = 16'h01ff;
  localparam logic [15:0] TOP_10BIT    = 16'h03ff;

  // input conditioning depth
  localparam int SYNC_STAGES    = 3;
  localparam int FILTER_SAMPLES = 4;

  // axi answers
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* design/tcc_timer16_capture.sv */
`timescale 1ns/1ps
module tcc_timer16_capture (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        timer_tick,
  input  wire logic        capture_event_pin,
  input  wire logic        comparator_output,
  input  wire logic        overflow_irq_ack,
  input  wire logic        capture_irq_ack,
  output logic             overflow_irq,
  output logic             capture_irq,
  output logic             count_at_bottom
);
  localparam int SYNC_STAGES_L = tcc_pkg::SYNC_STAGES;
  logic [7:0]  timer_control_a;
  logic [7:0]  timer_control_b;
  logic [7:0]  irq_mask;
  logic [7:0]  comparator_ctrl_status;
  logic [15:0] count_value;
  logic [15:0] capture_value;
  logic [15:0] compare_a;
  logic [15:0] compare_b;
  logic [7:0]  temp_high;
  logic        overflow_flag;
  logic        capture_flag;
  logic        count_up;
  logic [7:0]  aw_addr;
  logic [7:0]  w_data;
  logic        w_strb0;
  logic        aw_held;
  logic        w_held;
  logic        rd_fire;
  logic        wr_fire;
  logic        wr_en;
  logic        cnt_lo_wr;
  logic [3:0]  waveform_mode_select;
  logic [2:0]  clock_source_select;
  logic        tick;
  logic        dual_slope;
  logic        fast_pwm;
  logic        capture_top_mode;
  logic [15:0] count_top;
  logic [15:0] next_count;
  logic        next_up;
  logic        ovf_event;
  logic        capture_event;
  logic [SYNC_STAGES_L-1:0] pin_sync;
  logic [SYNC_STAGES_L-1:0] cmp_sync;
  logic        pin_level;
  logic        cmp_level;
  logic        src_level;
  logic [tcc_pkg::FILTER_SAMPLES-2:0] filter_shift;
  logic [tcc_pkg::FILTER_SAMPLES-1:0] filter_window;
  logic        filtered;
  logic        edge_in;
  logic        edge_prev;
  logic [7:0]  ar_addr;

  // mode is split across both control registers
  assign waveform_mode_select = {timer_control_b[tcc_pkg::CTRL_B_MODE_LSB +: 2],
                                 timer_control_a[tcc_pkg::CTRL_A_MODE_LSB +: 2]};
  assign clock_source_select = timer_control_b[tcc_pkg::CTRL_B_CLKSEL_LSB +: 3];
  assign tick = timer_tick & (clock_source_select != 3'h0);
  assign wr_en = wr_fire & w_strb0;
  assign cnt_lo_wr = wr_en & (aw_addr == tcc_pkg::OFS_COUNT_LO);

  // write fires once address and data are both held; a read in the same cycle goes first
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign ar_addr = {s_axi_araddr[7:2], 2'b00}; // low address bits ignored, as on the write side
  assign wr_fire = aw_held & w_held & ~s_axi_bvalid & ~rd_fire;

  // mode classes and top value
  always_comb
  begin
    dual_slope = 1'b0;
    fast_pwm = 1'b0;
    capture_top_mode = 1'b0;
    count_top = tcc_pkg::COUNT_MAX;
    case (waveform_mode_select)
      4'h1: begin dual_slope = 1'b1; count_top = tcc_pkg::TOP_8BIT; end
      4'h2: begin dual_slope = 1'b1; count_top = tcc_pkg::TOP_9BIT; end
      4'h3: begin dual_slope = 1'b1; count_top = tcc_pkg::TOP_10BIT; end
      4'h4: count_top = compare_a;
      4'h5: begin fast_pwm = 1'b1; count_top = tcc_pkg::TOP_8BIT; end
      4'h6: begin fast_pwm = 1'b1; count_top = tcc_pkg::TOP_9BIT; end
      4'h7: begin fast_pwm = 1'b1; count_top = tcc_pkg::TOP_10BIT; end
      4'h8, 4'ha: begin dual_slope = 1'b1; capture_top_mode = 1'b1; count_top = capture_value; end
      4'h9, 4'hb: begin dual_slope = 1'b1; count_top = compare_a; end
      4'hc: begin capture_top_mode = 1'b1; count_top = capture_value; end
      4'he: begin fast_pwm = 1'b1; capture_top_mode = 1'b1; count_top = capture_value; end
      4'hf: begin fast_pwm = 1'b1; count_top = compare_a; end
      default: count_top = tcc_pkg::COUNT_MAX; // normal and reserved
    endcase
  end

  // next counter value; the cpu write is applied last so it wins
  always_comb
  begin
    next_count = count_value;
    next_up = count_up;
    if (tick)
    begin
      if (dual_slope)
      begin
        if (count_up && count_value >= count_top)
        begin
          next_up = 1'b0;
          next_count = count_value - 16'h0001;
        end
        else if (!count_up && count_value == tcc_pkg::COUNT_BOTTOM)
        begin
          next_up = 1'b1;
          next_count = 16'h0001;
        end
        else if (count_up)
          next_count = count_value + 16'h0001;
        else
          next_count = count_value - 16'h0001;
      end
      else if (count_value >= count_top)
        next_count = tcc_pkg::COUNT_BOTTOM;
      else
        next_count = count_value + 16'h0001;
    end
    if (cnt_lo_wr)
      next_count = {temp_high, w_data};
  end

  // overflow: bottom in dual slope, top in fast pwm, max otherwise
  assign ovf_event = tick & (dual_slope ? (count_value == tcc_pkg::COUNT_BOTTOM && !count_up) :
                     fast_pwm ? (count_value == count_top) : (count_value == tcc_pkg::COUNT_MAX));

  // counter state and bottom status
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_value <= tcc_pkg::COUNT_RESET;
      count_up <= 1'b1;
      count_at_bottom <= 1'b1;
    end
    else
    begin
      count_value <= next_count;
      count_up <= next_up;
      count_at_bottom <= (next_count == tcc_pkg::COUNT_BOTTOM);
    end
  end

  // three-stage synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_sync <= '0;
      cmp_sync <= '0;
      pin_level <= 1'b0;
      cmp_level <= 1'b0;
    end
    else
    begin
      pin_sync <= {pin_sync[SYNC_STAGES_L-2:0], capture_event_pin};
      cmp_sync <= {cmp_sync[SYNC_STAGES_L-2:0], comparator_output};
      if (pin_sync[1] == pin_sync[2])
        pin_level <= pin_sync[2];
      if (cmp_sync[1] == cmp_sync[2])
        cmp_level <= cmp_sync[2];
    end
  end

  assign src_level = comparator_ctrl_status[tcc_pkg::CMP_CAPSEL_BIT] ? cmp_level : pin_level;

  // the live sample is the fourth of the window, so a steady change shows exactly four cycles late
  assign filter_window = {filter_shift, src_level};

  // noise filter on the system clock, never on the tick
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      filter_shift <= '0;
      filtered <= 1'b0;
    end
    else
    begin
      filter_shift <= filter_window[tcc_pkg::FILTER_SAMPLES-2:0];
      if (&filter_window)
        filtered <= 1'b1;
      else if (~|filter_window)
        filtered <= 1'b0;
    end
  end

  assign edge_in = timer_control_b[tcc_pkg::CTRL_B_FILTER_BIT] ? filtered : src_level;
  // edge select bit: 1 rising, 0 falling; input ignored while capture defines top
  assign capture_event = ~capture_top_mode & (edge_in != edge_prev) &
                         (edge_in == timer_control_b[tcc_pkg::CTRL_B_EDGE_BIT]);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      edge_prev <= 1'b0;
    else
      edge_prev <= edge_in;
  end

  // capture register: hardware copy, or cpu top value in capture-top modes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      capture_value <= tcc_pkg::COUNT_RESET;
    else if (capture_event)
      capture_value <= count_value;
    else if (wr_en && aw_addr == tcc_pkg::OFS_CAPTURE_LO && capture_top_mode)
      capture_value <= {temp_high, w_data};
  end

  // flags: a set in the clearing cycle wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      overflow_flag <= 1'b0;
      capture_flag <= 1'b0;
    end
    else
    begin
      if (ovf_event)
        overflow_flag <= 1'b1;
      else if (overflow_irq_ack || (wr_en && aw_addr == tcc_pkg::OFS_IRQ_FLAGS &&
               w_data[tcc_pkg::IRQ_OVERFLOW_BIT]))
        overflow_flag <= 1'b0;
      if (capture_event)
        capture_flag <= 1'b1;
      else if (capture_irq_ack || (wr_en && aw_addr == tcc_pkg::OFS_IRQ_FLAGS &&
               w_data[tcc_pkg::IRQ_CAPTURE_BIT]))
        capture_flag <= 1'b0;
    end
  end

  // interrupt requests gated by the mask
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      overflow_irq <= 1'b0;
      capture_irq <= 1'b0;
    end
    else
    begin
      overflow_irq <= overflow_flag & irq_mask[tcc_pkg::IRQ_OVERFLOW_BIT];
      capture_irq <= capture_flag & irq_mask[tcc_pkg::IRQ_CAPTURE_BIT];
    end
  end

  // shared temp: high-byte writes load it, count and capture low-byte reads latch into it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      temp_high <= 8'h00;
    else if (rd_fire && ar_addr == tcc_pkg::OFS_COUNT_LO)
      temp_high <= count_value[15:8];
    else if (rd_fire && ar_addr == tcc_pkg::OFS_CAPTURE_LO)
      temp_high <= capture_value[15:8];
    else if (wr_en && (aw_addr == tcc_pkg::OFS_COUNT_HI || aw_addr == tcc_pkg::OFS_CAPTURE_HI ||
             aw_addr == tcc_pkg::OFS_COMPARE_AHI || aw_addr == tcc_pkg::OFS_COMPARE_BHI))
      temp_high <= w_data;
  end

  // plain control and compare registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer_control_a <= tcc_pkg::CTRL_RESET;
      timer_control_b <= tcc_pkg::CTRL_RESET;
      irq_mask <= tcc_pkg::CTRL_RESET;
      comparator_ctrl_status <= tcc_pkg::CTRL_RESET;
      compare_a <= tcc_pkg::COUNT_RESET;
      compare_b <= tcc_pkg::COUNT_RESET;
    end
    else if (wr_en)
    begin
      case (aw_addr)
        tcc_pkg::OFS_CTRL_A: timer_control_a <= w_data;
        tcc_pkg::OFS_CTRL_B: timer_control_b <= w_data;
        tcc_pkg::OFS_IRQ_MASK: irq_mask <= w_data;
        tcc_pkg::OFS_CMP_CTRL: comparator_ctrl_status <= w_data;
        tcc_pkg::OFS_COMPARE_ALO: compare_a <= {temp_high, w_data};
        tcc_pkg::OFS_COMPARE_BLO: compare_b <= {temp_high, w_data};
        default: ;
      endcase
    end
  end

  // axi write channels: each handshake latched on its own, in any order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 8'h00;
      w_strb0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tcc_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
        aw_held <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data <= s_axi_wdata[7:0];
        w_strb0 <= s_axi_wstrb[0];
        w_held <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr <= tcc_pkg::OFS_CMP_CTRL) ? tcc_pkg::RESP_OKAY : tcc_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // axi read: data one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= tcc_pkg::RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= tcc_pkg::RESP_OKAY;
      case (ar_addr)
        tcc_pkg::OFS_CTRL_A: s_axi_rdata <= {24'h000000, timer_control_a};
        tcc_pkg::OFS_CTRL_B: s_axi_rdata <= {24'h000000, timer_control_b};
        tcc_pkg::OFS_COUNT_LO: s_axi_rdata <= {24'h000000, count_value[7:0]};
        tcc_pkg::OFS_COUNT_HI, tcc_pkg::OFS_CAPTURE_HI: s_axi_rdata <= {24'h000000, temp_high};
        tcc_pkg::OFS_CAPTURE_LO: s_axi_rdata <= {24'h000000, capture_value[7:0]};
        tcc_pkg::OFS_COMPARE_ALO: s_axi_rdata <= {24'h000000, compare_a[7:0]};
        tcc_pkg::OFS_COMPARE_AHI: s_axi_rdata <= {24'h000000, compare_a[15:8]};
        tcc_pkg::OFS_COMPARE_BLO: s_axi_rdata <= {24'h000000, compare_b[7:0]};
        tcc_pkg::OFS_COMPARE_BHI: s_axi_rdata <= {24'h000000, compare_b[15:8]};
        tcc_pkg::OFS_IRQ_MASK: s_axi_rdata <= {24'h000000, irq_mask};
        tcc_pkg::OFS_IRQ_FLAGS: s_axi_rdata <= {26'h0000000, capture_flag, 4'h0, overflow_flag};
        tcc_pkg::OFS_CMP_CTRL: s_axi_rdata <= {24'h000000, comparator_ctrl_status};
        default:
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= tcc_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // checks
  a_capture_copy: assert property (@(posedge aclk) disable iff (!aresetn)
    capture_event |=> capture_value == $past(count_value)) else $error("capture missed counter");
  a_capture_flag_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    capture_event |=> capture_flag && capture_value == $past(count_value)) else $error("flag late");
  a_count_write_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    cnt_lo_wr |=> count_value == {$past(temp_high), $past(w_data)}) else $error("count write lost");
  a_stopped_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    clock_source_select == 3'h0 && !cnt_lo_wr |=> $stable(count_value)) else $error("stopped moved");
  a_normal_step: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && !cnt_lo_wr && waveform_mode_select == 4'h0 |=> count_value == $past(count_value) + 16'h0001)
    else $error("bad step");
  a_bottom_tracks: assert property (@(posedge aclk) disable iff (!aresetn)
    count_at_bottom == (count_value == tcc_pkg::COUNT_BOTTOM)) else $error("bottom wrong");
  a_filter_agree: assert property (@(posedge aclk) disable iff (!aresetn)
    filter_window != '1 && filter_window != '0 |=> $stable(filtered)) else $error("filter glitch");
  a_top_mode_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    capture_top_mode && !capture_flag |=> !capture_flag) else $error("capture in top mode");
  a_overflow_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    ovf_event |=> overflow_flag ##1 (overflow_irq == irq_mask[tcc_pkg::IRQ_OVERFLOW_BIT] || !overflow_flag))
    else $error("overflow lost");
  a_capture_irq: assert property (@(posedge aclk) disable iff (!aresetn)
    capture_event && irq_mask[tcc_pkg::IRQ_CAPTURE_BIT] |=> ##1 capture_irq) else $error("no irq");
endmodule // tcc_timer16_capture

/* dv/tcc_event_source.sv */
`timescale 1ns/1ps
// far side of the capture unit: the event pin and the comparator output
// both are driven levels, never released, so each simply holds its last value
module tcc_event_source (
  input  wire logic aclk,
  output logic      capture_event_pin,
  output logic      comparator_output
);
  initial
  begin
    capture_event_pin = 1'b0;
    comparator_output = 1'b0;
  end

  // changes land just after an edge so no sampling race is possible
  task automatic set_pin(input logic v);
    @(posedge aclk);
    capture_event_pin <= v;
  endtask

  task automatic set_cmp(input logic v);
    @(posedge aclk);
    comparator_output <= v;
  endtask

  // pulse shorter than the filter window, a spike rather than an event
  task automatic glitch_pin(input int n);
    set_pin(~capture_event_pin);
    repeat (n) @(posedge aclk);
    capture_event_pin <= ~capture_event_pin;
  endtask
endmodule // tcc_event_source

/* dv/timer16_counter_input_capture_tb.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin bad_count++; $display("BAD %0t got %h want %h", $time, (got), (exp)); end end
module timer16_counter_input_capture_tb;
  typedef struct {logic [7:0] wa; logic [7:0] wd; logic [7:0] ra; logic [7:0] ex;} tcc_row_t;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        timer_tick, capture_event_pin, comparator_output, overflow_irq_ack, capture_irq_ack;
  logic        overflow_irq, capture_irq, count_at_bottom;
  logic [7:0]  q;
  int          bad_count, checks_done, cyc, n0, n1;
  // write one location, then read one back; the later rows lean on temp state left by earlier ones
  tcc_row_t rows [12] = '{
    '{8'h0c, 8'h12, 8'h0c, 8'h12}, '{8'h08, 8'h34, 8'h08, 8'h34}, '{8'h1c, 8'h56, 8'h0c, 8'h56},
    '{8'h2b, 8'h00, 8'h09, 8'h34}, '{8'h28, 8'h00, 8'h0c, 8'h12}, '{8'h18, 8'h78, 8'h18, 8'h78},
    '{8'h0c, 8'h9a, 8'h1c, 8'h12}, '{8'h20, 8'h02, 8'h24, 8'h9a}, '{8'h08, 8'h01, 8'h08, 8'h01},
    '{8'h28, 8'h00, 8'h0c, 8'h9a}, '{8'h34, 8'hff, 8'h34, 8'h00}, '{8'h04, 8'h05, 8'h04, 8'h05}};

  tcc_timer16_capture DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_tick,
    .capture_event_pin, .comparator_output, .overflow_irq_ack, .capture_irq_ack, .overflow_irq,
    .capture_irq, .count_at_bottom);
  tcc_event_source src (.aclk, .capture_event_pin, .comparator_output);

  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // hang guard, well above the few hundred cycles the sequence needs
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // one axi4-lite transfer; each request held until its own ready, answer taken at its handshake edge
  task automatic bus(input bit wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
    logic [1:0]  rsp;
    if (wr)
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= {a, ~a, a, d}; // upper lanes carry junk that must be ignored
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end
    else
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(wr ? s_axi_bvalid : s_axi_rvalid)); // no limit here; a reply that never comes is caught only by the bench timeout
    rsp = wr ? s_axi_bresp : s_axi_rresp;
    r = s_axi_rdata[7:0];
    if (!wr)
      `CHK(s_axi_rdata[31:8], 24'h000000)
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    `CHK(rsp, ({a[7:2], 2'b00} > 8'h30) ? tcc_pkg::RESP_SLVERR : tcc_pkg::RESP_OKAY)
    @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, q);
    `CHK(q, e)
  endtask

  // high location first, low write commits both bytes
  task automatic set16(input logic [7:0] hi, input logic [7:0] lo, input logic [15:0] v);
    wr(hi, v[15:8]);
    wr(lo, v[7:0]);
  endtask

  task automatic tick(input int n);
    repeat (n)
    begin
      timer_tick <= 1'b1;
      @(posedge aclk);
      timer_tick <= 1'b0;
      @(posedge aclk);
    end
  endtask

  task automatic pulse(input bit cap);
    if (cap) capture_irq_ack <= 1'b1; else overflow_irq_ack <= 1'b1;
    @(posedge aclk);
    capture_irq_ack <= 1'b0;
    overflow_irq_ack <= 1'b0;
    @(posedge aclk);
  endtask

  // cycles from a trigger change until the capture interrupt shows
  task automatic wait_cap(output int n);
    n = 0;
    while (capture_irq !== 1'b1 && n < 60)
    begin
      @(posedge aclk);
      n++;
    end
  endtask

  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {timer_tick, overflow_irq_ack, capture_irq_ack} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rows[i])
    begin
      wr(rows[i].wa, rows[i].wd);
      rd(rows[i].ra, rows[i].ex);
    end
    // a write without its low byte lane is answered but changes nothing
    s_axi_wstrb <= 4'he;
    wr(tcc_pkg::OFS_CTRL_A, 8'h03);
    s_axi_wstrb <= 4'hf;
    rd(tcc_pkg::OFS_CTRL_A, 8'h00);
    // counting: stopped, then up through the wrap, then dual slope, then clear at compare a
    wr(tcc_pkg::OFS_CTRL_B, 8'h00);
    wr(tcc_pkg::OFS_IRQ_MASK, 8'h21);
    set16(tcc_pkg::OFS_COUNT_HI, tcc_pkg::OFS_COUNT_LO, 16'hfffe);
    tick(3);
    rd(tcc_pkg::OFS_COUNT_LO, 8'hfe);
    `CHK(count_at_bottom, 1'b0)
    wr(tcc_pkg::OFS_CTRL_B, 8'h01);
    tick(1);
    rd(tcc_pkg::OFS_COUNT_LO, 8'hff);
    tick(1);
    rd(tcc_pkg::OFS_COUNT_LO, 8'h00);
    rd(tcc_pkg::OFS_COUNT_HI, 8'h00);
    `CHK(count_at_bottom, 1'b1)
    rd(tcc_pkg::OFS_IRQ_FLAGS, 8'h01);
    `CHK(overflow_irq, 1'b1)
    pulse(1'b0);
    rd(tcc_pkg::OFS_IRQ_FLAGS, 8'h00);
    wr(tcc_pkg::OFS_CTRL_A, 8'h01);
    set16(tcc_pkg::OFS_COUNT_HI, tcc_pkg::OFS_COUNT_LO, 16'h00fe);
    tick(2);
    rd(tcc_pkg::OFS_COUNT_LO, 8'hfe);
    wr(tcc_pkg::OFS_CTRL_A, 8'h00);
    wr(tcc_pkg::OFS_CTRL_B, 8'h09);
    set16(tcc_pkg::OFS_COUNT_HI, tcc_pkg::OFS_COUNT_LO, 16'h1277);
    tick(2);
    rd(tcc_pkg::OFS_COUNT_LO, 8'h00);
    rd(tcc_pkg::OFS_COUNT_HI, 8'h00);
    // capture on a rising pin edge with the counter parked
    wr(tcc_pkg::OFS_CTRL_B, 8'h40);
    set16(tcc_pkg::OFS_COUNT_HI, tcc_pkg::OFS_COUNT_LO, 16'h4321);
    src.set_pin(1'b1);
    wait_cap(n0);
    `CHK(capture_irq, 1'b1)
    rd(tcc_pkg::OFS_CAPTURE_LO, 8'h21);
    rd(tcc_pkg::OFS_CAPTURE_HI, 8'h43);
    rd(tcc_pkg::OFS_IRQ_FLAGS, 8'h20);
    wr(tcc_pkg::OFS_IRQ_FLAGS, 8'h20);
    rd(tcc_pkg::OFS_IRQ_FLAGS, 8'h00);
    // falling edge overwrites the earlier capture
    wr(tcc_pkg::OFS_CTRL_B, 8'h00);
    set16(tcc_pkg::OFS_COUNT_HI, tcc_pkg::OFS_COUNT_LO, 16'h5555);
    src.set_pin(1'b0);
    wait_cap(n1);
    rd(tcc_pkg::OFS_CAPTURE_LO, 8'h55);
    wr(tcc_pkg::OFS_IRQ_FLAGS, 8'h20);
    // filter: a spike is swallowed, a real edge arrives four cycles later than unfiltered
    wr(tcc_pkg::OFS_CTRL_B, 8'hc0);
    src.glitch_pin(3);
    repeat (20) @(posedge aclk);
    rd(tcc_pkg::OFS_IRQ_FLAGS, 8'h00);
    src.set_pin(1'b1);
    wait_cap(n1);
    `CHK(n1 - n0, 4)
    pulse(1'b1);
    rd(tcc_pkg::OFS_IRQ_FLAGS, 8'h00);
    // comparator as trigger; the source switch may fake an event, so flag cleared after it
    wr(tcc_pkg::OFS_CTRL_B, 8'h40);
    wr(tcc_pkg::OFS_CMP_CTRL, 8'h04);
    wr(tcc_pkg::OFS_IRQ_FLAGS, 8'h20);
    set16(tcc_pkg::OFS_COUNT_HI, tcc_pkg::OFS_COUNT_LO, 16'h6789);
    src.set_cmp(1'b1);
    wait_cap(n1);
    rd(tcc_pkg::OFS_CAPTURE_LO, 8'h89);
    wr(tcc_pkg::OFS_IRQ_FLAGS, 8'h20);
    // capture register writable only when it sets the top
    set16(tcc_pkg::OFS_CAPTURE_HI, tcc_pkg::OFS_CAPTURE_LO, 16'h1122);
    rd(tcc_pkg::OFS_CAPTURE_LO, 8'h89);
    wr(tcc_pkg::OFS_CTRL_B, 8'h18);
    set16(tcc_pkg::OFS_CAPTURE_HI, tcc_pkg::OFS_CAPTURE_LO, 16'h7788);
    rd(tcc_pkg::OFS_CAPTURE_LO, 8'h88);
    rd(tcc_pkg::OFS_CAPTURE_HI, 8'h77);
    src.set_cmp(1'b0);
    src.set_pin(1'b0);
    repeat (20) @(posedge aclk);
    rd(tcc_pkg::OFS_IRQ_FLAGS, 8'h00);
    // second reset in mid-run
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(tcc_pkg::OFS_COUNT_LO, 8'h00);
    rd(tcc_pkg::OFS_COUNT_HI, 8'h00);
    rd(tcc_pkg::OFS_CAPTURE_LO, 8'h00);
    rd(tcc_pkg::OFS_IRQ_FLAGS, 8'h00);
    `CHK(count_at_bottom, 1'b1)
    tally_and_finish();
  end
endmodule // timer16_counter_input_capture_tb
